// ===== core/lrse_pkg.sv
package lrse_pkg;

    // -------------------------------------------------
    // Sizes
    // -------------------------------------------------
    localparam int NRULE = 16;
    localparam int NTMR  = 4;
    localparam int NCNT  = 4;

    // -------------------------------------------------
    // Timing (125 MHz clock)
    // -------------------------------------------------
    localparam int CLK_MHZ       = 125;
    localparam int CYC_BASE_US   = 600;
    localparam int CYC_RULE_US   = 370;
    localparam int TICK_US       = 1000;
    localparam int CYC_BASE_CLKS = CYC_BASE_US * CLK_MHZ;
    localparam int CYC_RULE_CLKS = CYC_RULE_US * CLK_MHZ;
    localparam int TICK_CLKS     = TICK_US * CLK_MHZ;

    // -------------------------------------------------
    // Register map (byte addresses)
    // -------------------------------------------------
    localparam logic [11:0] A_CTRL   = 12'h000;
    localparam logic [11:0] A_STATUS = 12'h004;
    localparam logic [11:0] A_DI     = 12'h008;
    localparam logic [11:0] A_DO     = 12'h00c;
    localparam logic [11:0] A_FLAGS  = 12'h010;
    localparam logic [11:0] A_TOGGLE = 12'h014;
    localparam logic [11:0] A_TPRE   = 12'h020;
    localparam logic [11:0] A_TVAL   = 12'h030;
    localparam logic [11:0] A_CNT    = 12'h040;
    localparam logic [11:0] A_RULE   = 12'h100;
    localparam logic [11:0] A_MON    = 12'h200;
    localparam logic [11:0] A_MON_END = 12'h240;

    localparam int CTRL_RUN_BIT = 0;
    localparam int CTRL_MON_BIT = 1;

    // -------------------------------------------------
    // Encodings
    // -------------------------------------------------
    localparam logic [1:0] CLS_NONE = 2'h0;
    localparam logic [1:0] CLS_DI   = 2'h1;
    localparam logic [1:0] CLS_FLAG = 2'h2;
    localparam logic [1:0] CLS_TMR  = 2'h3;

    localparam logic [1:0] OP_AND  = 2'h0;
    localparam logic [1:0] OP_OR   = 2'h1;
    localparam logic [1:0] OP_NAND = 2'h2;
    localparam logic [1:0] OP_NOR  = 2'h3;

    localparam logic [1:0] ACT_DO   = 2'h0;
    localparam logic [1:0] ACT_FLAG = 2'h1;
    localparam logic [1:0] ACT_TMR  = 2'h2;
    localparam logic [1:0] ACT_CNT  = 2'h3;

    typedef struct packed {
        logic       inv;
        logic [1:0] cls;
        logic [3:0] idx;
    } lrse_cond_t;

    typedef struct packed {
        logic [6:0] pad;
        lrse_cond_t c2;
        lrse_cond_t c1;
        lrse_cond_t c0;
        logic [1:0] op;
        logic       chain;
        logic       en;
    } lrse_rule_t;

    typedef struct packed {
        logic [15:0] period;
        logic [8:0]  pad;
        logic        inv;
        logic [3:0]  idx;
        logic [1:0]  kind;
    } lrse_act_t;

    typedef enum logic [2:0] {ST_IDLE, ST_LOGIC, ST_EXEC, ST_OUT, ST_WAIT} lrse_state_t;

endpackage : lrse_pkg

// ===== core/lrse_engine.sv
// Contract
// - Host downloads all rule settings first; engine stores them as its project.
// - Run command starts executing the project and status shows running.
// - Monitoring only while running, enabled on host request.
// - Monitoring reports stages reached per rule and present condition values.
// - While monitoring, host may toggle internal flags at runtime.
// - Sixteen rule slots, each enabled or disabled; disabled ones do nothing.
// - Each cycle: logic phase of all, then execution, then output.
// - Outputs and flags update only in output phase; seen next cycle. Host toggle writes change flags at once, in any phase.
// - At most three input conditions per rule.
// - Chain option feeds result only into the immediately following rule.
// - Any rule output may drive a flag read by any rule.
// - Each condition matches true or false level, inverting the input.
// - Execution stage has a repeat interval pacing how often rule acts.
// - Scan cycle about 600 plus 370 times n microseconds.
// - Single rule input-to-output delay below one millisecond.
// - Two rules linked by a flag form a set/reset latch.
// - Chained AND rules drive output high only while all inputs high.
// - Trigger starts timer and first output; later outputs follow timed intervals. Here pacing runs from run start, not from a trigger.
// - Timer runs while result true, stops and clears while false, or reverse.
// - Edge mode counter increments once when result becomes true.
// - Flag used as input and output: written value is next input.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module lrse_engine #(
    parameter int CYC_BASE = lrse_pkg::CYC_BASE_CLKS,
    parameter int CYC_RULE = lrse_pkg::CYC_RULE_CLKS,
    parameter int TICK     = lrse_pkg::TICK_CLKS
) (
    // Clock and reset
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Field I/O
    input  wire logic [15:0] di_i,
    output logic      [15:0] do_o,
    output logic             running_o
);
    import lrse_pkg::*;

    // -------------------------------------------------
    // State
    // -------------------------------------------------
    lrse_rule_t  rule_q [NRULE];
    lrse_act_t   act_q  [NRULE];
    logic [15:0] tpre_q [NTMR];
    logic [15:0] tval_q [NTMR];
    logic [15:0] cnt_q  [NCNT];
    logic [7:0]  mon_q  [NRULE];
    logic [NTMR-1:0]  trun_q;
    logic [NTMR-1:0]  tdone;
    logic [NRULE-1:0] res_q;
    logic [NRULE-1:0] go_q;
    logic [NRULE-1:0] prev_q;
    logic [15:0] flags_q;
    logic [15:0] flags_d;
    logic [15:0] do_q;
    logic        run_q;
    logic        mon_q_en;
    logic        mon_act;
    lrse_state_t state_q;
    logic [3:0]  idx_q;
    logic [31:0] cyc_q;
    logic [31:0] cyc_target;
    logic [31:0] tick_cnt_q;
    logic        tick;
    logic [31:0] prdata_q;
    logic        err_q;
    logic [31:0] rd_d;
    logic        err_d;
    logic        acc;
    logic        wr_en;
    logic        start;
    logic        tog_we;
    logic        res_d;
    logic [2:0]  cv_d;
    lrse_rule_t  cur;
    lrse_act_t   cur_act;
    logic        out_fire;
    logic        out_val;

    // -------------------------------------------------
    // APB slave: data latched in setup, zero wait
    // -------------------------------------------------
    assign acc       = psel_i & penable_i;
    assign pready_o  = acc;
    assign pslverr_o = acc & err_q;
    assign prdata_o  = prdata_q;
    assign wr_en     = acc & pwrite_i & ~err_q;

    always_comb begin
        rd_d  = 32'h0000_0000;
        err_d = 1'b0;
        if (paddr_i[1:0] != 2'b00) begin
            err_d = 1'b1;
        end else if (paddr_i >= A_RULE && paddr_i < A_MON) begin
            // Rule and action words are frozen while running; timer presets stay writable
            err_d = pwrite_i & run_q;
            rd_d  = paddr_i[2] ? act_q[paddr_i[6:3]] : rule_q[paddr_i[6:3]];
        end else if (paddr_i >= A_MON && paddr_i < A_MON_END) begin
            err_d = pwrite_i;
            rd_d  = {24'h00_0000, mon_q[paddr_i[5:2]]};
        end else if (paddr_i[11:4] == A_TPRE[11:4]) begin
            rd_d  = {16'h0000, tpre_q[paddr_i[3:2]]};
        end else if (paddr_i[11:4] == A_TVAL[11:4]) begin
            err_d = pwrite_i;
            rd_d  = {16'h0000, tval_q[paddr_i[3:2]]};
        end else if (paddr_i[11:4] == A_CNT[11:4]) begin
            err_d = pwrite_i;
            rd_d  = {16'h0000, cnt_q[paddr_i[3:2]]};
        end else begin
            case (paddr_i)
                A_CTRL:   rd_d = {30'h0000_0000, mon_q_en, run_q};
                A_STATUS: rd_d = {29'h0000_0000, state_q};
                A_DI: begin
                    err_d = pwrite_i;
                    rd_d  = {16'h0000, di_i};
                end
                A_DO: begin
                    err_d = pwrite_i;
                    rd_d  = {16'h0000, do_q};
                end
                A_FLAGS: begin
                    err_d = pwrite_i;
                    rd_d  = {16'h0000, flags_q};
                end
                A_TOGGLE: err_d = ~pwrite_i | ~mon_act;
                default:  err_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
            err_q    <= 1'b0;
        end else if (psel_i && !penable_i) begin
            prdata_q <= rd_d;
            err_q    <= err_d;
        end
    end

    // -------------------------------------------------
    // Project storage
    // -------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            for (int i = 0; i < NRULE; i++) begin
                rule_q[i] <= '0;
                act_q[i]  <= '0;
            end
            for (int t = 0; t < NTMR; t++) begin
                tpre_q[t] <= 16'h0000;
            end
        end else if (wr_en) begin
            if (paddr_i >= A_RULE && paddr_i < A_MON) begin
                if (paddr_i[2]) begin
                    act_q[paddr_i[6:3]]  <= pwdata_i;
                end else begin
                    rule_q[paddr_i[6:3]] <= pwdata_i;
                end
            end else if (paddr_i[11:4] == A_TPRE[11:4]) begin
                tpre_q[paddr_i[3:2]] <= pwdata_i[15:0];
            end
        end
    end

    // -------------------------------------------------
    // Run and monitor control
    // -------------------------------------------------
    assign start   = wr_en && paddr_i == A_CTRL && pwdata_i[CTRL_RUN_BIT] && !run_q;
    assign mon_act = run_q & mon_q_en;
    assign tog_we  = wr_en && paddr_i == A_TOGGLE;
    assign running_o = run_q;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            run_q    <= 1'b0;
            mon_q_en <= 1'b0;
        end else if (wr_en && paddr_i == A_CTRL) begin
            run_q    <= pwdata_i[CTRL_RUN_BIT];
            mon_q_en <= pwdata_i[CTRL_MON_BIT] & pwdata_i[CTRL_RUN_BIT];
        end
    end

    // -------------------------------------------------
    // Millisecond tick and scan sequencer
    // -------------------------------------------------
    assign tick = (tick_cnt_q == 32'(TICK - 1));

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || tick) begin
            tick_cnt_q <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
        end
    end

    // Cycle length follows the enabled rule count
    assign cyc_target = 32'(CYC_BASE) + 32'(CYC_RULE) * 32'($countones(go_mask()));

    function automatic logic [NRULE-1:0] go_mask();
        logic [NRULE-1:0] m;
        m = '0;
        for (int i = 0; i < NRULE; i++) begin
            m[i] = rule_q[i].en;
        end
        return m;
    endfunction : go_mask

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || !run_q || start) begin
            state_q <= ST_IDLE;
            idx_q   <= 4'h0;
            cyc_q   <= 32'h0000_0000;
        end else begin
            cyc_q <= cyc_q + 32'h0000_0001;
            case (state_q)
                ST_IDLE: state_q <= ST_LOGIC;
                ST_LOGIC, ST_EXEC, ST_OUT: begin
                    idx_q <= idx_q + 4'h1;
                    if (idx_q == 4'hf) begin
                        state_q <= state_q == ST_LOGIC ? ST_EXEC :
                                   state_q == ST_EXEC  ? ST_OUT  : ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // A one-rule project ends at 970 us, just under the 1 ms budget
                    if (cyc_q >= cyc_target - 32'h0000_0001) begin
                        state_q <= ST_LOGIC;
                        cyc_q   <= 32'h0000_0000;
                    end
                end
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    // -------------------------------------------------
    // Logic phase: three conditions plus chain input
    // -------------------------------------------------
    assign cur     = rule_q[idx_q];
    assign cur_act = act_q[idx_q];

    always_comb begin
        lrse_cond_t c [3];
        logic [3:0] v;
        logic [3:0] u;
        c[0] = cur.c0;
        c[1] = cur.c1;
        c[2] = cur.c2;
        v    = 4'h0;
        u    = 4'h0;
        for (int k = 0; k < 3; k++) begin
            case (c[k].cls)
                CLS_DI:   v[k] = di_i[c[k].idx];
                CLS_FLAG: v[k] = flags_q[c[k].idx];
                CLS_TMR:  v[k] = tdone[c[k].idx[1:0]];
                default:  v[k] = 1'b0;
            endcase
            v[k] = v[k] ^ c[k].inv;
            u[k] = c[k].cls != CLS_NONE;
        end
        // Only the slot just below may chain in
        if (idx_q != 4'h0 && rule_q[idx_q - 4'h1].en && rule_q[idx_q - 4'h1].chain) begin
            v[3] = res_q[idx_q - 4'h1];
            u[3] = 1'b1;
        end
        cv_d = v[2:0];
        case (cur.op)
            OP_AND:  res_d = &(v | ~u);
            OP_OR:   res_d = |(v & u);
            OP_NAND: res_d = ~&(v | ~u);
            OP_NOR:  res_d = ~|(v & u);
            default: res_d = 1'b0;
        endcase
    end

    // -------------------------------------------------
    // Per-rule result, pacing and monitor
    // -------------------------------------------------
    for (genvar g = 0; g < NRULE; g++) begin : g_rule
        logic [15:0] elap_q;
        logic        here;
        assign here = (idx_q == 4'(g)) && rule_q[g].en;

        always_ff @(posedge clock_i) begin
            if (!rst_n_i || start) begin
                res_q[g] <= 1'b0;
            end else if (state_q == ST_LOGIC && here) begin
                res_q[g] <= res_d;
            end
        end

        always_ff @(posedge clock_i) begin
            if (!rst_n_i || start) begin
                elap_q  <= 16'h0000;
                go_q[g] <= 1'b0;
            end else if (state_q == ST_EXEC && here) begin
                // Zero period means every cycle
                if (elap_q >= act_q[g].period) begin
                    go_q[g] <= 1'b1;
                    elap_q  <= 16'h0000;
                end else begin
                    go_q[g] <= 1'b0;
                end
            end else if (tick && elap_q != 16'hffff) begin
                elap_q <= elap_q + 16'h0001;
            end
        end

        always_ff @(posedge clock_i) begin
            if (!rst_n_i || !mon_act) begin
                mon_q[g] <= 8'h00;
            end else if (here) begin
                case (state_q)
                    ST_LOGIC: mon_q[g] <= {1'b0, cv_d, res_d, 3'b001};
                    ST_EXEC:  mon_q[g][1] <= 1'b1;
                    ST_OUT:   mon_q[g][2] <= go_q[g];
                    default:  mon_q[g] <= mon_q[g];
                endcase
            end
        end
    end

    // -------------------------------------------------
    // Output phase actions
    // -------------------------------------------------
    // Chained rules hand their result on instead of acting
    assign out_fire = state_q == ST_OUT && cur.en && go_q[idx_q] && !cur.chain;
    assign out_val  = res_q[idx_q] ^ cur_act.inv;
    assign do_o     = do_q;

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            do_q <= 16'h0000;
        end else if (out_fire && cur_act.kind == ACT_DO) begin
            do_q[cur_act.idx] <= out_val;
        end
    end

    // Toggle applied after rule write so neither is lost
    always_comb begin
        flags_d = flags_q;
        if (out_fire && cur_act.kind == ACT_FLAG) begin
            flags_d[cur_act.idx] = out_val;
        end
        if (tog_we) begin
            flags_d = flags_d ^ pwdata_i[15:0];
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            flags_q <= 16'h0000;
        end else begin
            flags_q <= flags_d;
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            trun_q <= '0;
        end else if (out_fire && cur_act.kind == ACT_TMR) begin
            trun_q[cur_act.idx[1:0]] <= out_val;
        end
    end

    for (genvar t = 0; t < NTMR; t++) begin : g_tmr
        assign tdone[t] = trun_q[t] && tval_q[t] >= tpre_q[t];
        always_ff @(posedge clock_i) begin
            if (!rst_n_i || !trun_q[t]) begin
                tval_q[t] <= 16'h0000;
            end else if (tick && tval_q[t] != 16'hffff) begin
                tval_q[t] <= tval_q[t] + 16'h0001;
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_n_i || start) begin
            for (int k = 0; k < NCNT; k++) begin
                cnt_q[k] <= 16'h0000;
            end
            prev_q <= '0;
        end else if (out_fire && cur_act.kind == ACT_CNT) begin
            prev_q[idx_q] <= res_q[idx_q];
            if (cur_act.inv) begin
                if (res_q[idx_q]) begin
                    cnt_q[cur_act.idx[1:0]] <= 16'h0000;
                end
            end else if (res_q[idx_q] && !prev_q[idx_q]) begin
                cnt_q[cur_act.idx[1:0]] <= cnt_q[cur_act.idx[1:0]] + 16'h0001;
            end
        end
    end

    // -------------------------------------------------
    // Assertions
    // -------------------------------------------------
    a_mon_needs_run: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !run_q |=> mon_q[0] == 8'h00) else $error("monitor shown while stopped");

    a_cfg_write_locked: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (psel_i && !penable_i && pwrite_i && run_q && paddr_i >= A_RULE && paddr_i < A_MON)
        ##1 (psel_i && penable_i) |-> pslverr_o) else $error("config write not refused");

    a_start_clears: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        start |=> (flags_q == 16'h0000 && do_q == 16'h0000 && cnt_q[0] == 16'h0000))
        else $error("start did not clear state");

    a_run_begins: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        start |=> run_q && state_q == ST_IDLE ##1 state_q == ST_LOGIC)
        else $error("run did not begin scan");

    a_phase_order: assert property (@(posedge clock_i) disable iff (!rst_n_i || !run_q)
        (run_q && state_q == ST_LOGIC && idx_q == 4'hf && !start) |=>
        (state_q == ST_EXEC && idx_q == 4'h0)[*1] ##16 state_q == ST_OUT)
        else $error("phase order broken");

    a_flag_only_out: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (flags_q != $past(flags_q) && !$past(start) && !$past(tog_we)) |->
        $past(state_q) == ST_OUT) else $error("flag changed outside output phase");

    a_toggle_flags: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (tog_we && !out_fire && !start) |=> flags_q == ($past(flags_q) ^ $past(pwdata_i[15:0])))
        else $error("flag toggle not applied");

    a_disabled_quiet: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (state_q == ST_OUT && !cur.en && !start) |=> do_q == $past(do_q))
        else $error("disabled rule changed output");

    a_timer_clear: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        !trun_q[0] |=> tval_q[0] == 16'h0000) else $error("stopped timer not cleared");

    a_edge_once: assert property (@(posedge clock_i) disable iff (!rst_n_i)
        (cnt_q[0] != $past(cnt_q[0]) && cnt_q[0] != 16'h0000) |->
        cnt_q[0] == $past(cnt_q[0]) + 16'h0001) else $error("counter jumped");

endmodule : lrse_engine

// ===== sim/lrse_host.sv
`timescale 1ns/1ps
module lrse_host (
    // Clock
    input  wire logic        clock_i,
    // APB answer
    input  wire logic [31:0] prdata_i,
    input  wire logic        pready_i,
    input  wire logic        pslverr_i,
    // APB request
    output logic             psel_o,
    output logic             penable_o,
    output logic             pwrite_o,
    output logic      [11:0] paddr_o,
    output logic      [31:0] pwdata_o
);
    initial begin
        psel_o    = 1'b0;
        penable_o = 1'b0;
        pwrite_o  = 1'b0;
        paddr_o   = 12'h000;
        pwdata_o  = 32'h0000_0000;
    end

    // -------------------------------------------------
    // One transfer; the project is downloaded through it
    // -------------------------------------------------
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic err, output logic to);
        int n;
        n = 0;
        @(posedge clock_i);
        psel_o    <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o  <= w;
        paddr_o   <= a;
        pwdata_o  <= d;
        @(posedge clock_i);
        penable_o <= 1'b1;
        do begin
            @(posedge clock_i);
            n++;
        end while (pready_i !== 1'b1 && n < 50);
        q   = prdata_i;
        err = pslverr_i;
        to  = (pready_i !== 1'b1);
        psel_o    <= 1'b0;
        penable_o <= 1'b0;
        // Released bus shows no stale value
        paddr_o   <= ~a;
        pwdata_o  <= ~d;
    endtask : xfer
endmodule : lrse_host

// ===== sim/lrse_engine_tb.sv
`timescale 1ns/1ps
module lrse_engine_tb;
    import lrse_pkg::*;
    localparam int SETTLE = 3 * (100 + 20 * 10) + 10;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, running;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] di = 16'h0000;
    logic [15:0] do_w;
    logic [15:0] d;
    int n_errors = 0;
    int n_tests  = 0;
    int seed     = 69721;
    lrse_cond_t nc = '0;

    initial forever #4 clock_i = ~clock_i;

    lrse_engine #(.CYC_BASE(100), .CYC_RULE(20), .TICK(10)) uut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .di_i(di), .do_o(do_w), .running_o(running));
    lrse_host host (
        .clock_i(clock_i), .prdata_i(prdata), .pready_i(pready), .pslverr_i(pslverr),
        .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite), .paddr_o(paddr),
        .pwdata_o(pwdata));

    // -------------------------------------------------
    // Helpers
    // -------------------------------------------------
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] dw,
                       input logic e, output logic [31:0] q);
        logic x, t;
        host.xfer(w, a, dw, q, x, t);
        if (t) begin
            n_errors++;
            $display("wrong value at %0t: bus never answered", $time);
            end_of_test();
        end else begin
            chk({31'h0, x}, {31'h0, e}, "bus error flag");
        end
    endtask : bus

    task automatic settle;
        repeat (SETTLE) @(posedge clock_i);
    endtask : settle

    // Monitor bits of all rules are only complete during the wait state
    task automatic to_wait;
        logic seen;
        seen = 1'b0;
        for (int k = 0; k < 200; k++) begin
            bus(1'b0, A_STATUS, 32'h0, 1'b0, r);
            if (seen && r[2:0] == ST_WAIT) return;
            seen = (r[2:0] != ST_WAIT);
        end
        n_errors++;
        $display("wrong value at %0t: scan never waited", $time);
        end_of_test();
    endtask : to_wait

    function automatic logic [31:0] exp_do(input logic [15:0] v);
        return {25'h0, 1'b0, v[9], 1'b0, &v[7:2], 1'b0, ~v[1], v[0]};
    endfunction : exp_do

    function automatic lrse_cond_t cd(input logic i, input logic [1:0] c, input logic [3:0] x);
        return '{inv: i, cls: c, idx: x};
    endfunction : cd

    function automatic logic [31:0] rl(input logic en, input logic ch, input lrse_cond_t a,
                                       input lrse_cond_t b, input lrse_cond_t c);
        return {7'h00, c, b, a, OP_AND, ch, en};
    endfunction : rl

    function automatic logic [31:0] ac(input logic [1:0] k, input logic [3:0] x);
        return {16'h0000, 9'h000, 1'b0, x, k};
    endfunction : ac

    task automatic put(input int i, input logic [31:0] c, input logic [31:0] a);
        bus(1'b1, A_RULE + 12'(8 * i), c, 1'b0, r);
        bus(1'b1, A_RULE + 12'(8 * i + 4), a, 1'b0, r);
    endtask : put

    // -------------------------------------------------
    // Main sequence
    // -------------------------------------------------
    initial begin
        repeat (5) @(posedge clock_i);
        rst_n_i <= 1'b1;
        chk({15'h0, running, do_w}, 32'h0, "reset outputs");
        put(0, rl(1, 0, cd(0, CLS_DI, 0), nc, nc), ac(ACT_DO, 0));
        put(1, rl(1, 0, cd(1, CLS_DI, 1), nc, nc), ac(ACT_DO, 1));
        put(2, rl(1, 0, cd(0, CLS_FLAG, 0), nc, nc), ac(ACT_DO, 2));
        put(3, rl(1, 1, cd(0, CLS_DI, 2), cd(0, CLS_DI, 3), cd(0, CLS_DI, 4)), ac(ACT_DO, 15));
        put(4, rl(1, 0, cd(0, CLS_DI, 5), cd(0, CLS_DI, 6), cd(0, CLS_DI, 7)), ac(ACT_DO, 3));
        put(5, rl(0, 0, cd(1, CLS_DI, 8), nc, nc), ac(ACT_DO, 4));
        put(6, rl(1, 0, cd(0, CLS_DI, 9), nc, nc), ac(ACT_FLAG, 1));
        put(7, rl(1, 0, cd(0, CLS_FLAG, 1), nc, nc), ac(ACT_DO, 5));
        put(8, rl(1, 0, cd(0, CLS_DI, 10), nc, nc), ac(ACT_CNT, 0));
        put(9, rl(1, 0, cd(0, CLS_DI, 11), nc, nc), ac(ACT_TMR, 0));
        put(10, rl(1, 0, cd(0, CLS_TMR, 0), nc, nc), ac(ACT_DO, 6));
        bus(1'b1, A_TPRE, 32'h0000_0002, 1'b0, r);
        bus(1'b1, A_CTRL, 32'h0000_0001, 1'b0, r);
        @(posedge clock_i);
        chk({31'h0, running}, 32'h1, "running after run command");
        bus(1'b1, A_RULE, 32'h0000_0000, 1'b1, r);
        bus(1'b1, 12'h018, 32'h0000_0000, 1'b1, r);
        $display("test download done");
        for (int i = 0; i < 6; i++) begin
            d = (i == 0) ? 16'h02ff : 16'($random(seed)) & 16'h03ff;
            @(posedge clock_i);
            di <= d;
            settle();
            chk({16'h0, do_w}, exp_do(d), "outputs");
            bus(1'b0, A_FLAGS, 32'h0, 1'b0, r);
            chk({30'h0, r[1:0]}, {30'h0, d[9], 1'b0}, "flag written by rule");
        end
        $display("test random logic done");
        bus(1'b0, A_MON, 32'h0, 1'b0, r);
        chk(r, 32'h0, "monitor off");
        @(posedge clock_i);
        di <= 16'h0001;
        bus(1'b1, A_CTRL, 32'h0000_0003, 1'b0, r);
        settle();
        to_wait();
        bus(1'b0, A_MON, 32'h0, 1'b0, r);
        chk({27'h0, r[4:0]}, 32'h0000_001f, "monitor of rule 0");
        bus(1'b0, A_MON + 12'h014, 32'h0, 1'b0, r);
        chk({29'h0, r[2:0]}, 32'h0, "monitor of disabled rule");
        bus(1'b1, A_TOGGLE, 32'h0000_0001, 1'b0, r);
        settle();
        chk({31'h0, do_w[2]}, 32'h1, "toggled flag drives output");
        bus(1'b1, A_CTRL, 32'h0000_0001, 1'b0, r);
        bus(1'b1, A_TOGGLE, 32'h0000_0001, 1'b1, r);
        $display("test monitoring done");
        for (int i = 0; i < 3; i++) begin
            @(posedge clock_i);
            di <= (i == 1) ? 16'h0000 : 16'h0400;
            settle();
        end
        bus(1'b0, A_CNT, 32'h0, 1'b0, r);
        chk(r, 32'h2, "edge counter");
        @(posedge clock_i);
        di <= 16'h0800;
        settle();
        chk({31'h0, do_w[6]}, 32'h1, "timer done");
        @(posedge clock_i);
        di <= 16'h0000;
        settle();
        bus(1'b0, A_TVAL, 32'h0, 1'b0, r);
        chk({r[30:0], do_w[6]}, 32'h0, "timer cleared");
        $display("test counter and timer done");
        bus(1'b1, A_CTRL, 32'h0000_0000, 1'b0, r);
        @(posedge clock_i);
        chk({31'h0, running}, 32'h0, "stopped");
        put(5, rl(1, 0, cd(1, CLS_DI, 8), nc, nc) | {28'h0, OP_NOR, 2'h0},
            ac(ACT_DO, 4) | 32'h0000_0040);
        bus(1'b1, A_CTRL, 32'h0000_0001, 1'b0, r);
        bus(1'b0, A_FLAGS, 32'h0, 1'b0, r);
        chk(r, 32'h0, "flags cleared on start");
        bus(1'b0, A_CNT, 32'h0, 1'b0, r);
        chk(r, 32'h0, "counter cleared on start");
        settle();
        chk({31'h0, do_w[4]}, 32'h1, "inverted nor rule");
        $display("test restart done");
        end_of_test();
    end
endmodule : lrse_engine_tb
